/* File: shared/aro_pkg.sv */
// Constants for the converter result output port: frame layout, widths,
// reset values. Assumes a single 250 MHz system clock domain.
package aro_pkg;
  localparam int RES_BITS = 12;            // Result word width
  localparam int LEAD_ZEROS = 4;           // Zero bits ahead of the result
  localparam int FRAME_BITS = 16;          // Bits in one serial frame
  localparam int SYNC_W = 5;               // Synchronised pin count
  // Positions of the synchronised pins
  localparam int SY_MODE = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_FS = 2;
  localparam int SY_RD = 3;
  localparam int SY_CS = 4;
  // Rising clock edges needed to walk a frame down to its last bit
  localparam logic [3:0] LAST_SHIFT = 4'hf;
  // Values after reset
  localparam logic [RES_BITS-1:0] RES_RST = 12'h000;
  localparam logic [FRAME_BITS-1:0] SHIFT_RST = 16'h0000;
  // Pins idle high; mode reads parallel, so with read high every pin floats
  // until the real strap has come through the synchroniser
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h1f;
  localparam logic [1:0] TEST_RST = 2'h0;  // Test pins tied low
  typedef enum logic {ARO_IDLE, ARO_SHIFT} aro_frame_t;
endpackage : aro_pkg

/* File: logic/aro_port.sv */
// Result output port of a 12-bit converter: three-state parallel word or
// 16-bit serial frame clocked by the host.
// Assumes the converter core hands over results on mclk_in with a pulse;
// all pins are asynchronous to mclk_in and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module aro_port #(
  parameter bit BIPOLAR = 1'b1             // 1: bipolar range variant
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Converter core side
  input wire logic [aro_pkg::RES_BITS-1:0] result_in,
  input wire logic result_valid_in,
  // Host control pins
  input wire logic interface_select_in,
  input wire logic serial_clock_in,
  input wire logic frame_sync_in,
  input wire logic read_n_in,
  input wire logic chip_select_n_in,
  // Test pins in serial mode, read back only
  input wire logic top_bit_test_in,
  input wire logic second_bit_test_in,
  // Shared data pins, enables low while driving
  output logic top_bit_or_test_pin_out,
  output logic top_bit_or_test_pin_oe_n_out,
  output logic second_bit_or_test_pin_out,
  output logic second_bit_or_test_pin_oe_n_out,
  output logic result_bit_nine_out,
  output logic result_bit_eight_out,
  output logic result_bit_seven_out,
  output logic result_bit_six_out,
  output logic [3:0] result_nine_six_oe_n_out,
  output logic bit_five_or_serial_out,
  output logic bit_five_or_serial_oe_n_out,
  output logic [4:0] result_low_out,
  output logic [4:0] result_low_oe_n_out
);
  import aro_pkg::*;

  // Reset release synchroniser
  logic rst_meta;
  logic rst_n;
  // Pin synchronisers: first stage feeds only the second
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_pin;
  logic sclk_prev;                         // Last synchronised serial clock
  // Test pin synchroniser; the host straps these pins, never this block
  logic [1:0] test_meta;
  logic [1:0] test_sync;
  // Held result and frame state
  logic [RES_BITS-1:0] held;
  logic [FRAME_BITS-1:0] shift;
  logic [3:0] shift_cnt;
  aro_frame_t frame;
  // Registered pin drive
  logic [RES_BITS-1:0] pin_data;
  logic [RES_BITS-1:0] pin_oe_n;
  // Next values
  logic [RES_BITS-1:0] next_held;
  logic [FRAME_BITS-1:0] next_shift;
  logic [3:0] next_shift_cnt;
  aro_frame_t next_frame;
  logic [RES_BITS-1:0] next_pin_data;
  logic [RES_BITS-1:0] next_pin_oe_n;
  // Decoded conditions
  logic parallel_mode;
  logic sclk_rise;
  logic fs_low;
  logic test_pins_high;                    // Host has broken the tie-low

  // Core hands natural binary; bipolar parts flip the sign bit
  // Unipolar parts pass the word on untouched as natural binary
  function automatic logic [RES_BITS-1:0] encode(input logic [RES_BITS-1:0] raw);
    encode = BIPOLAR ? {~raw[RES_BITS-1], raw[RES_BITS-2:0]} : raw;
  endfunction : encode

  // Reset release through two flip-flops
  // Assertion is immediate; release waits two edges so that every flop
  // leaves reset on the same clock and none sees a runt release
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Pin synchronisers and serial clock history
  // The host clock is sampled, not used as a clock: each of its phases
  // must last at least two mclk_in periods or an edge is lost
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= SYNC_RST;
      sync_pin <= SYNC_RST;
      sclk_prev <= 1'b1;
    end else begin
      sync_meta <= {chip_select_n_in, read_n_in, frame_sync_in,
                    serial_clock_in, interface_select_in};
      sync_pin <= sync_meta;
      sclk_prev <= sync_pin[SY_SCLK];
    end
  end

  // Test pins come from outside as well, so they take the same two
  // stages before any decode may look at them
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      test_meta <= TEST_RST;
      test_sync <= TEST_RST;
    end else begin
      test_meta <= {top_bit_test_in, second_bit_test_in};
      test_sync <= test_meta;
    end
  end

  // Decodes from synchronised pins only
  always_comb begin
    parallel_mode = sync_pin[SY_MODE];
    // Rising edge of the host clock as seen behind the synchroniser
    sclk_rise = sync_pin[SY_SCLK] & ~sclk_prev;
    fs_low = ~sync_pin[SY_FS];
    // Visible for debug only; these pins are the host's to hold low.
    // Nothing acts on it: a broken tie-low is a board fault, not a mode.
    test_pins_high = ~parallel_mode & (|test_sync);
  end

  // Next result, frame and pin values
  always_comb begin
    next_held = held;
    next_shift = shift;
    next_shift_cnt = shift_cnt;
    next_frame = frame;
    next_pin_data = pin_data;
    next_pin_oe_n = {RES_BITS{1'b1}};
    // A new result is taken at once; a frame in flight keeps its copy
    if (result_valid_in) begin
      next_held = encode(result_in);
    end
    // The counter stops at the last bit, so host edges beyond the
    // fifteenth leave bit 0 on the line instead of wrapping round
    case (frame)
      ARO_IDLE: begin
        // Frame sync falling loads zeros ahead of the result
        if (!parallel_mode && fs_low) begin
          next_shift = {{LEAD_ZEROS{1'b0}}, held};
          next_shift_cnt = 4'h0;
          next_frame = ARO_SHIFT;
        end
      end
      ARO_SHIFT: begin
        if (parallel_mode || !fs_low) begin
          // Frame ended by sync rising or a mode change
          // A cut frame is not resumed: the next sync low reloads from
          // the newest held result
          next_frame = ARO_IDLE;
        end else if (sclk_rise && shift_cnt != LAST_SHIFT) begin
          // Each rising edge moves the next bit up, MSB first
          next_shift = {shift[FRAME_BITS-2:0], 1'b0};
          next_shift_cnt = shift_cnt + 4'h1;
        end
      end
      default: begin
        next_frame = ARO_IDLE;
      end
    endcase
    if (parallel_mode) begin
      // Data follows the held word even while floating, so a read that
      // opens the drivers never shows a stale word
      next_pin_data = held;
      // Three-state word, driven only under read and select
      if (!sync_pin[SY_RD] && !sync_pin[SY_CS]) begin
        next_pin_oe_n = {RES_BITS{1'b0}};
      end
    end else begin
      // Serial: only the bit-5 pin drives; 11..6 and 4..0 float
      next_pin_data = {RES_BITS{1'b0}};
      next_pin_data[5] = next_shift[FRAME_BITS-1];
      next_pin_oe_n[5] = 1'b0;
    end
  end

  // State registers
  // Reset floats every pin and clears the held word
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      held <= RES_RST;
      shift <= SHIFT_RST;
      shift_cnt <= 4'h0;
      frame <= ARO_IDLE;
      pin_data <= RES_RST;
      pin_oe_n <= {RES_BITS{1'b1}};
    end else begin
      held <= next_held;
      shift <= next_shift;
      shift_cnt <= next_shift_cnt;
      frame <= next_frame;
      pin_data <= next_pin_data;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // Pin mapping straight from the drive registers
  // Pure wiring: every output still comes straight from a flip-flop
  always_comb begin
    top_bit_or_test_pin_out = pin_data[11];
    top_bit_or_test_pin_oe_n_out = pin_oe_n[11];
    second_bit_or_test_pin_out = pin_data[10];
    second_bit_or_test_pin_oe_n_out = pin_oe_n[10];
    result_bit_nine_out = pin_data[9];
    result_bit_eight_out = pin_data[8];
    result_bit_seven_out = pin_data[7];
    result_bit_six_out = pin_data[6];
    result_nine_six_oe_n_out = pin_oe_n[9:6];
    bit_five_or_serial_out = pin_data[5];
    bit_five_or_serial_oe_n_out = pin_oe_n[5];
    result_low_out = pin_data[4:0];
    result_low_oe_n_out = pin_oe_n[4:0];
  end
endmodule : aro_port
`default_nettype wire

/* File: tb/aro_port_properties.sv */
// Pin-level checker for the result output port.
// Assumes it is bound onto aro_port and that pins settle within six clocks.
`timescale 1ns/1ns
`default_nettype none
module aro_port_properties #(parameter bit BIPOLAR = 1'b1) (
  // Watched ports
  input wire logic mclk_in, nrst_in, result_valid_in, interface_select_in,
  input wire logic serial_clock_in, frame_sync_in, read_n_in, chip_select_n_in,
  input wire logic [11:0] result_in,
  input wire logic top_bit_or_test_pin_out, top_bit_or_test_pin_oe_n_out,
  input wire logic second_bit_or_test_pin_out, second_bit_or_test_pin_oe_n_out,
  input wire logic result_bit_nine_out, result_bit_eight_out,
  input wire logic result_bit_seven_out, result_bit_six_out,
  input wire logic [3:0] result_nine_six_oe_n_out,
  input wire logic bit_five_or_serial_out, bit_five_or_serial_oe_n_out,
  input wire logic [4:0] result_low_out, result_low_oe_n_out
);
  logic [11:0] held; // Coded copy of the last result
  logic [15:0] frm; // Frame the host should receive
  logic [4:0] cnt; // Falling serial edges so far in the frame
  logic rd_on; // Host asks for the parallel word
  logic ser_fall; // Serial clock low inside a serial frame
  assign rd_on = !read_n_in && !chip_select_n_in && interface_select_in;
  assign ser_fall = !interface_select_in && !frame_sync_in && !serial_clock_in && cnt < 16;
  // Shadow model; frame load and falling-edge count live here so the assertions stay plain
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      held <= 12'h000;
      frm <= 16'h0000;
      cnt <= 5'h00;
    end else begin
      if (result_valid_in) held <= result_in ^ {BIPOLAR, 11'h000};
      if ($fell(frame_sync_in)) frm <= {4'h0, held};
      if (frame_sync_in) cnt <= 5'h00;
      else if ($fell(serial_clock_in)) cnt <= cnt + 5'h01;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  a_par_oe_gate: assert property (!top_bit_or_test_pin_oe_n_out |->
    $past(rd_on, 2) || $past(rd_on, 3) || $past(rd_on, 4)) else $error("enable without read");
  a_par_drive_on: assert property (rd_on [*6] |->
    !top_bit_or_test_pin_oe_n_out && result_low_oe_n_out == 5'h00) else $error("read ignored");
  a_oe_group_same: assert property (
    second_bit_or_test_pin_oe_n_out == top_bit_or_test_pin_oe_n_out
    && result_nine_six_oe_n_out == {4{top_bit_or_test_pin_oe_n_out}})
    else $error("enables split");
  a_par_data_word: assert property (
    !top_bit_or_test_pin_oe_n_out && !$past(result_valid_in) && !$past(result_valid_in, 2)
    |-> {top_bit_or_test_pin_out, second_bit_or_test_pin_out,
    result_bit_nine_out, result_bit_eight_out, result_bit_seven_out, result_bit_six_out,
    bit_five_or_serial_out, result_low_out} == held) else $error("word wrong");
  a_ser_floats: assert property ((!interface_select_in) [*6] |->
    top_bit_or_test_pin_oe_n_out && &result_nine_six_oe_n_out) else $error("serial drives bus");
  a_ser_drives: assert property ((!interface_select_in) [*6] |->
    !bit_five_or_serial_oe_n_out) else $error("serial line idle");
  a_ser_bit_order: assert property (ser_fall && $fell(serial_clock_in) |->
    bit_five_or_serial_out == frm[4'hf - cnt[3:0]]) else $error("serial bit wrong");
  a_lead_zeros: assert property (ser_fall && cnt < 4 |->
    bit_five_or_serial_out == 1'b0) else $error("lead bit not zero");
endmodule : aro_port_properties
bind aro_port aro_port_properties #(.BIPOLAR(BIPOLAR)) i_aro_port_properties (.*);
`default_nettype wire

/* File: tb/aro_host_model.sv */
// Host serial port: makes frame sync and clock, samples on falling edges.
// Assumes the port is in serial mode whenever get_frame runs.
`timescale 1ns/1ns
`default_nettype none
module aro_host_model (
  // Serial pins
  input wire logic sdata_in,
  output logic sclk_out,
  output logic fs_n_out
);
  // Clock stands high and sync idles high outside frames
  initial begin
    sclk_out = 1'b1;
    fs_n_out = 1'b1;
  end
  // One sixteen-bit frame, first bit first
  task automatic get_frame(output logic [15:0] w);
    // Step off the clock edge on which the caller returned
    #1;
    fs_n_out = 1'b0;
    #49;
    repeat (16) begin
      sclk_out = 1'b0;
      w = {w[14:0], sdata_in};
      #24 sclk_out = 1'b1;
      #24;
    end
    fs_n_out = 1'b1;
    #48;
  endtask : get_frame
endmodule : aro_host_model
`default_nettype wire

/* File: tb/aro_port_bench.sv */
// Self-checking bench for the result output port in both modes.
// Assumes the host model on the serial pins; a unipolar copy shares every input.
`timescale 1ns/1ns
`default_nettype none
module aro_port_bench;
  logic mclk_in = 1'b0, nrst_in = 1'b0, result_valid_in = 1'b0;
  logic interface_select_in = 1'b1, read_n_in = 1'b1, chip_select_n_in = 1'b1;
  logic top_bit_test_in = 1'b0, second_bit_test_in = 1'b0;
  logic [11:0] result_in = 12'h000;
  logic serial_clock_in, frame_sync_in, sd, top_bit_or_test_pin_out, top_bit_or_test_pin_oe_n_out;
  logic second_bit_or_test_pin_out, second_bit_or_test_pin_oe_n_out, result_bit_nine_out;
  logic result_bit_eight_out, result_bit_seven_out, result_bit_six_out;
  logic bit_five_or_serial_out, bit_five_or_serial_oe_n_out;
  logic [3:0] result_nine_six_oe_n_out;
  logic [4:0] result_low_out, result_low_oe_n_out;
  logic [11:0] word, oe_n;
  int fail_count = 0, total_checks = 0;
  assign word = {top_bit_or_test_pin_out, second_bit_or_test_pin_out, result_bit_nine_out,
    result_bit_eight_out, result_bit_seven_out, result_bit_six_out, bit_five_or_serial_out,
    result_low_out};
  assign oe_n = {top_bit_or_test_pin_oe_n_out, second_bit_or_test_pin_oe_n_out,
    result_nine_six_oe_n_out, bit_five_or_serial_oe_n_out, result_low_oe_n_out};
  // A released serial line shows the inverse of its last value
  assign sd = bit_five_or_serial_out ^ bit_five_or_serial_oe_n_out;
  always #2 mclk_in = ~mclk_in;
  aro_port i_aro_port (.*);
  aro_host_model i_aro_host_model (.sdata_in(sd), .sclk_out(serial_clock_in),
    .fs_n_out(frame_sync_in));
  // Unipolar copy: same inputs, its parallel word is read back as well
  wire [11:0] uni_word;
  aro_port #(.BIPOLAR(1'b0)) i_aro_port_uni (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .result_in(result_in), .result_valid_in(result_valid_in),
    .interface_select_in(interface_select_in), .serial_clock_in(serial_clock_in),
    .frame_sync_in(frame_sync_in), .read_n_in(read_n_in),
    .chip_select_n_in(chip_select_n_in), .top_bit_test_in(top_bit_test_in),
    .second_bit_test_in(second_bit_test_in), .top_bit_or_test_pin_out(uni_word[11]),
    .top_bit_or_test_pin_oe_n_out(), .second_bit_or_test_pin_out(uni_word[10]),
    .second_bit_or_test_pin_oe_n_out(), .result_bit_nine_out(uni_word[9]),
    .result_bit_eight_out(uni_word[8]), .result_bit_seven_out(uni_word[7]),
    .result_bit_six_out(uni_word[6]), .result_nine_six_oe_n_out(),
    .bit_five_or_serial_out(uni_word[5]), .bit_five_or_serial_oe_n_out(),
    .result_low_out(uni_word[4:0]), .result_low_oe_n_out());
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic capture(logic [11:0] v);
    @(posedge mclk_in) result_in <= v;
    result_valid_in <= 1'b1;
    @(posedge mclk_in) result_valid_in <= 1'b0;
  endtask : capture
  // Every read and select combination, then a new result mid-read
  task automatic t_parallel();
    capture(12'ha5c);
    for (int i = 3; i >= 0; i--) begin
      @(posedge mclk_in) {read_n_in, chip_select_n_in} <= i[1:0];
      repeat (8) @(negedge mclk_in);
      check("oe_n", oe_n, (i == 0) ? 12'h000 : 12'hfff);
    end
    check("word", word, 12'h25c);
    check("uni word", uni_word, 12'ha5c);
    capture(12'h0f3);
    repeat (3) @(negedge mclk_in);
    check("word", word, 12'h8f3);
    check("uni word", uni_word, 12'h0f3);
    $display("parallel test done");
  endtask : t_parallel
  // Boundary results sent back to back; read stays low to test refusal
  task automatic t_serial();
    logic [15:0] w;
    logic [11:0] v[3] = '{12'h801, 12'h7fe, 12'hfff};
    @(posedge mclk_in) interface_select_in <= 1'b0;
    repeat (8) @(negedge mclk_in);
    check("oe_n", oe_n, 12'hfdf);
    foreach (v[k]) begin
      capture(v[k]);
      i_aro_host_model.get_frame(w);
      check("frame", w, {4'h0, v[k] ^ 12'h800});
    end
    $display("serial test done");
  endtask : t_serial
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    t_parallel();
    t_serial();
    stop_test();
  end
  // Watchdog well past the expected run length
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
endmodule : aro_port_bench
`default_nettype wire
